// file: sptc_top.sv
// sweep trigger and pulse trigger chain control with an avalon-mm slave
// assumes trigger pins are asynchronous; group trigger comes from same-clock logic
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps

// Function
// - immediate trigger fires sweep only when armed
// - bus source fires on group or common trigger
// - immediate source: trigger condition always true
// - hold source fires a sweep only on the immediate trigger command
// - sweep source holds exactly one selection
// - immediate source plus continuous gives auto retrigger
// - pulse trigger chain independent of sweep trigger
// - edge polarity picks rising or falling, rising default
// - polarity used only in gate, edge modes
// - free running: pulses at rate, ignore trigger
// - gate window: gated pulses at internal rate
// - offset repeat: periodic pulses shifted by offset
// - edge started: edge starts pulses, no offset
// - edge started offset: edge starts delayed pulses
// - external modulate: one delayed pulse, also modulates
// - pulse mode holds exactly one of six
// - gate and modulate modes need count one
// - no offset in free, gate, edge modes
// - input select front or rear, front default
// - input select only matters in external modes
// - trigger sweep command: abort then initiate
module sptc_top
  import sptc_pkg::*;
#(
  parameter int unsigned CNT_W = 32
)(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        group_trigger_i,
  input  wire logic        front_trigger_input_i,
  input  wire logic        rear_trigger_input_i,
  output logic             sweep_start_o,
  output logic             sweep_armed_o,
  output logic             pulse_o,
  output logic             pulse_modulate_o
);

  // decode a written mode code; illegal codes report not valid
  function automatic logic mode_valid(input logic [2:0] code);
    mode_valid = (code <= SPTC_MC_EXTMOD);
  endfunction

  function automatic sptc_mode_t mode_decode(input logic [2:0] code);
    unique case (code)
      SPTC_MC_GATE:   mode_decode = SPTC_M_GATE;
      SPTC_MC_OFSREP: mode_decode = SPTC_M_OFSREP;
      SPTC_MC_EDGE:   mode_decode = SPTC_M_EDGE;
      SPTC_MC_EDGOFS: mode_decode = SPTC_M_EDGOFS;
      SPTC_MC_EXTMOD: mode_decode = SPTC_M_EXTMOD;
      default:        mode_decode = SPTC_M_FREE;
    endcase
  endfunction

  function automatic logic [2:0] mode_encode(input sptc_mode_t m);
    unique case (m)
      SPTC_M_GATE:   mode_encode = SPTC_MC_GATE;
      SPTC_M_OFSREP: mode_encode = SPTC_MC_OFSREP;
      SPTC_M_EDGE:   mode_encode = SPTC_MC_EDGE;
      SPTC_M_EDGOFS: mode_encode = SPTC_MC_EDGOFS;
      SPTC_M_EXTMOD: mode_encode = SPTC_MC_EXTMOD;
      default:       mode_encode = SPTC_MC_FREE;
    endcase
  endfunction

  // bus slave
  logic        ack_reg;
  logic        wr_go;
  logic [31:0] rd_next;
  logic [31:0] rd_reg;

  // one wait cycle, then the answer
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_go             = avs_write_i & ack_reg;
  assign avs_readdata_o    = rd_reg;

  // configuration
  logic [1:0]       src_reg;
  logic             cont_reg;
  sptc_mode_t       mode_reg;
  logic             pol_reg;
  logic             inp_reg;
  logic [7:0]       count_reg;
  logic [CNT_W-1:0] period_reg;
  logic [CNT_W-1:0] offset_reg;
  logic [CNT_W-1:0] width_reg;
  logic             cmd_init;
  logic             cmd_abort;
  logic             cmd_trig;
  logic             cmd_common;
  logic             cmd_tsw;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      src_reg  <= SPTC_SRC_BUS;
      cont_reg <= 1'b0;
    end
    else if (wr_go && avs_address_i == SPTC_CTRL_OFS && avs_byteenable_i[0])
    begin
      // a new source replaces the old; unknown code is dropped
      if (avs_writedata_i[SPTC_CTRL_SRC_LSB +: 2] != 2'h3)
        src_reg <= avs_writedata_i[SPTC_CTRL_SRC_LSB +: 2];
      cont_reg <= avs_writedata_i[SPTC_CTRL_CONT_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode_reg  <= SPTC_M_FREE;
      pol_reg   <= 1'b0;
      inp_reg   <= 1'b0;
      count_reg <= SPTC_CNT_RST;
    end
    else if (wr_go && avs_address_i == SPTC_PCFG_OFS)
    begin
      if (avs_byteenable_i[0])
      begin
        if (mode_valid(avs_writedata_i[SPTC_PCFG_MODE_LSB +: 3]))
          mode_reg <= mode_decode(avs_writedata_i[SPTC_PCFG_MODE_LSB +: 3]);
        pol_reg <= avs_writedata_i[SPTC_PCFG_POL_BIT];
        inp_reg <= avs_writedata_i[SPTC_PCFG_INP_BIT];
      end
      if (avs_byteenable_i[1])
        count_reg <= avs_writedata_i[SPTC_PCFG_CNT_LSB +: 8];
    end
  end

  // timing words take whole-word writes only, so a half-written value never runs
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      period_reg <= CNT_W'(SPTC_PERIOD_RST);
      offset_reg <= CNT_W'(SPTC_OFFSET_RST);
      width_reg  <= CNT_W'(SPTC_WIDTH_RST);
    end
    else if (wr_go && avs_byteenable_i == 4'hf)
    begin
      if (avs_address_i == SPTC_PERIOD_OFS)
        period_reg <= CNT_W'(avs_writedata_i);
      if (avs_address_i == SPTC_OFFSET_OFS)
        offset_reg <= CNT_W'(avs_writedata_i);
      if (avs_address_i == SPTC_WIDTH_OFS)
        width_reg <= CNT_W'(avs_writedata_i);
    end
  end

  assign cmd_init   = wr_go && avs_address_i == SPTC_CMD_OFS && avs_writedata_i[SPTC_CMD_INIT_BIT];
  assign cmd_abort  = wr_go && avs_address_i == SPTC_CMD_OFS && avs_writedata_i[SPTC_CMD_ABORT_BIT];
  assign cmd_trig   = wr_go && avs_address_i == SPTC_CMD_OFS && avs_writedata_i[SPTC_CMD_TRIG_BIT];
  assign cmd_common = wr_go && avs_address_i == SPTC_CMD_OFS && avs_writedata_i[SPTC_CMD_COMMON_BIT];
  assign cmd_tsw    = wr_go && avs_address_i == SPTC_CMD_OFS && avs_writedata_i[SPTC_CMD_TSW_BIT];

  // sweep trigger
  logic        armed_reg;
  logic        src_event;
  logic        fire;
  logic [15:0] sweep_cnt_reg;

  always_comb
  begin
    unique case (src_reg)
      SPTC_SRC_BUS:  src_event = group_trigger_i | cmd_common;
      SPTC_SRC_IMM:  src_event = 1'b1;
      default:       src_event = 1'b0;
    endcase
  end

  // an event while unarmed is simply not kept
  assign fire = armed_reg & ~cmd_abort & ~cmd_tsw & (src_event | cmd_trig);

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      armed_reg <= 1'b0;
    else if (cmd_abort | cmd_tsw)
      armed_reg <= cmd_tsw | cmd_init | cont_reg;
    else if (fire)
      armed_reg <= 1'b0;  // a start uses up the arming, keeps start a strobe
    else if (cmd_init)
      armed_reg <= 1'b1;
    else if (cont_reg)
      armed_reg <= 1'b1;  // continuous re-arms a cycle after each start
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sweep_start_o <= 1'b0;
      sweep_cnt_reg <= 16'h0000;
    end
    else
    begin
      sweep_start_o <= fire;
      if (fire)
        sweep_cnt_reg <= sweep_cnt_reg + 16'h0001;
    end
  end

  assign sweep_armed_o = armed_reg;

  // pulse trigger chain
  // separate from the sweep path; nothing here reads the sweep state
  logic [1:0] pin_in;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] prev_reg;

  assign pin_in = {rear_trigger_input_i, front_trigger_input_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          prev_reg[gi]  <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= pin_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi]  <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  logic ext_mode;
  logic pol_mode;
  logic ofs_mode;
  logic bad_cfg;
  logic ext_lvl;
  logic ext_prv;
  logic act_lvl;
  logic act_edge;

  assign ext_mode = mode_reg inside {SPTC_M_GATE, SPTC_M_EDGE, SPTC_M_EDGOFS, SPTC_M_EXTMOD};
  assign pol_mode = mode_reg inside {SPTC_M_GATE, SPTC_M_EDGE, SPTC_M_EDGOFS};
  assign ofs_mode = mode_reg inside {SPTC_M_OFSREP, SPTC_M_EDGOFS, SPTC_M_EXTMOD};
  assign bad_cfg  = (mode_reg inside {SPTC_M_GATE, SPTC_M_EXTMOD}) && count_reg != 8'h01;

  // input chosen after sync so a select change never glitches a stage
  assign ext_lvl  = ext_mode & (inp_reg ? sync2_reg[1] : sync2_reg[0]);
  assign ext_prv  = ext_mode & (inp_reg ? prev_reg[1] : prev_reg[0]);
  // falling edge only where polarity counts; modulate takes rising
  assign act_lvl  = (pol_mode & pol_reg) ? ~ext_lvl & ext_mode : ext_lvl;
  assign act_edge = (pol_mode & pol_reg) ? (ext_prv & ~ext_lvl) : (~ext_prv & ext_lvl);

  // internal repetition clock
  logic [CNT_W-1:0] prf_cnt_reg;
  logic             prf_tick;

  assign prf_tick = (prf_cnt_reg == '0);

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      prf_cnt_reg <= '0;
    else if (prf_cnt_reg >= period_reg - CNT_W'(1))
      prf_cnt_reg <= '0;
    else
      prf_cnt_reg <= prf_cnt_reg + CNT_W'(1);
  end

  logic start_req;

  always_comb
  begin
    unique case (mode_reg)
      SPTC_M_FREE:   start_req = prf_tick;
      SPTC_M_GATE:   start_req = prf_tick & act_lvl;
      SPTC_M_OFSREP: start_req = prf_tick;
      SPTC_M_EDGE:   start_req = act_edge;
      SPTC_M_EDGOFS: start_req = act_edge;
      SPTC_M_EXTMOD: start_req = act_edge;
      default:       start_req = 1'b0;
    endcase
  end

  // sequencer: optional offset wait, then one pulse, or a burst of count pulses at the rate in the edge modes
  sptc_seq_t        seq_reg;
  logic [CNT_W-1:0] dly_reg;
  logic [7:0]       left_reg;
  logic [CNT_W-1:0] wid_reg;
  logic             emit;
  logic             burst_mode;

  assign burst_mode = mode_reg inside {SPTC_M_EDGE, SPTC_M_EDGOFS};

  always_comb
  begin
    emit = 1'b0;
    unique case (seq_reg)
      SPTC_SQ_IDLE:  emit = start_req & ~bad_cfg & ~(ofs_mode && offset_reg != '0);
      SPTC_SQ_WAIT:  emit = (dly_reg == CNT_W'(1));
      SPTC_SQ_BURST: emit = (dly_reg == CNT_W'(1));
      default:       emit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      seq_reg  <= SPTC_SQ_IDLE;
      dly_reg  <= '0;
      left_reg <= 8'h00;
    end
    else if (bad_cfg)
      seq_reg <= SPTC_SQ_IDLE;  // invalid setup stays silent
    else
    begin
      unique case (seq_reg)
        SPTC_SQ_IDLE:
          if (start_req)
          begin
            left_reg <= burst_mode ? count_reg : 8'h01;
            if (ofs_mode && offset_reg != '0)
            begin
              seq_reg <= SPTC_SQ_WAIT;
              dly_reg <= offset_reg;
            end
            else
            begin
              left_reg <= burst_mode && count_reg > 8'h01 ? count_reg - 8'h01 : 8'h00;
              seq_reg  <= burst_mode && count_reg > 8'h01 ? SPTC_SQ_BURST : SPTC_SQ_IDLE;
              dly_reg  <= period_reg;
            end
          end
        SPTC_SQ_WAIT, SPTC_SQ_BURST:
          if (emit)
          begin
            left_reg <= left_reg - 8'h01;
            dly_reg  <= period_reg;
            seq_reg  <= left_reg > 8'h01 ? SPTC_SQ_BURST : SPTC_SQ_IDLE;
          end
          else
            dly_reg <= dly_reg - CNT_W'(1);
        default:
          seq_reg <= SPTC_SQ_IDLE;
      endcase
    end
  end

  // pulse width timer; modulate follows the pulse only in its mode
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wid_reg          <= '0;
      pulse_o          <= 1'b0;
      pulse_modulate_o <= 1'b0;
    end
    else
    begin
      if (emit)
        wid_reg <= width_reg;
      else if (wid_reg != '0)
        wid_reg <= wid_reg - CNT_W'(1);
      pulse_o          <= emit | (wid_reg > CNT_W'(1));
      pulse_modulate_o <= (mode_reg == SPTC_M_EXTMOD) & (emit | (wid_reg > CNT_W'(1)));
    end
  end

  // read path
  always_comb
  begin
    rd_next = 32'h0000_0000;
    unique case (avs_address_i)
      SPTC_CTRL_OFS:
      begin
        rd_next[SPTC_CTRL_SRC_LSB +: 2] = src_reg;
        rd_next[SPTC_CTRL_CONT_BIT]     = cont_reg;
      end
      SPTC_PCFG_OFS:
      begin
        rd_next[SPTC_PCFG_MODE_LSB +: 3] = mode_encode(mode_reg);
        rd_next[SPTC_PCFG_POL_BIT]       = pol_reg;
        rd_next[SPTC_PCFG_INP_BIT]       = inp_reg;
        rd_next[SPTC_PCFG_CNT_LSB +: 8]  = count_reg;
      end
      SPTC_PERIOD_OFS: rd_next = 32'(period_reg);
      SPTC_OFFSET_OFS: rd_next = 32'(offset_reg);
      SPTC_WIDTH_OFS:  rd_next = 32'(width_reg);
      SPTC_STATUS_OFS:
      begin
        rd_next[SPTC_STAT_ARMED_BIT]     = armed_reg;
        rd_next[SPTC_STAT_BAD_BIT]       = bad_cfg;
        rd_next[SPTC_STAT_PULSE_BIT]     = pulse_o;
        rd_next[SPTC_STAT_BUSY_BIT]      = (seq_reg != SPTC_SQ_IDLE);
        rd_next[SPTC_STAT_SWP_LSB +: 16] = sweep_cnt_reg;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_reg <= 32'h0000_0000;
    else if (avs_read_i & ~ack_reg)
      rd_reg <= rd_next;
  end

endmodule

// file: sptc_pkg.sv
// constants shared by the sweep and pulse trigger control block
// assumes a 32-bit avalon-mm register bus with byte addresses
package sptc_pkg;

  // register byte offsets
  localparam logic [4:0] SPTC_CTRL_OFS   = 5'h00;
  localparam logic [4:0] SPTC_CMD_OFS    = 5'h04;
  localparam logic [4:0] SPTC_PCFG_OFS   = 5'h08;
  localparam logic [4:0] SPTC_PERIOD_OFS = 5'h0c;
  localparam logic [4:0] SPTC_OFFSET_OFS = 5'h10;
  localparam logic [4:0] SPTC_WIDTH_OFS  = 5'h14;
  localparam logic [4:0] SPTC_STATUS_OFS = 5'h18;

  // control register fields
  localparam int SPTC_CTRL_SRC_LSB  = 0;
  localparam int SPTC_CTRL_CONT_BIT = 2;

  // command register bits (write one to act)
  localparam int SPTC_CMD_INIT_BIT  = 0;
  localparam int SPTC_CMD_ABORT_BIT = 1;
  localparam int SPTC_CMD_TRIG_BIT  = 2;
  localparam int SPTC_CMD_COMMON_BIT = 3;
  localparam int SPTC_CMD_TSW_BIT   = 4;

  // pulse configuration fields
  localparam int SPTC_PCFG_MODE_LSB = 0;
  localparam int SPTC_PCFG_POL_BIT  = 3;
  localparam int SPTC_PCFG_INP_BIT  = 4;
  localparam int SPTC_PCFG_CNT_LSB  = 8;

  // status register fields
  localparam int SPTC_STAT_ARMED_BIT = 0;
  localparam int SPTC_STAT_BAD_BIT   = 1;
  localparam int SPTC_STAT_PULSE_BIT = 2;
  localparam int SPTC_STAT_BUSY_BIT  = 3;
  localparam int SPTC_STAT_SWP_LSB   = 16;

  // sweep trigger source codes
  localparam logic [1:0] SPTC_SRC_BUS  = 2'h0;
  localparam logic [1:0] SPTC_SRC_IMM  = 2'h1;
  localparam logic [1:0] SPTC_SRC_HOLD = 2'h2;

  // pulse trigger mode codes as software writes them
  localparam logic [2:0] SPTC_MC_FREE   = 3'h0;
  localparam logic [2:0] SPTC_MC_GATE   = 3'h1;
  localparam logic [2:0] SPTC_MC_OFSREP = 3'h2;
  localparam logic [2:0] SPTC_MC_EDGE   = 3'h3;
  localparam logic [2:0] SPTC_MC_EDGOFS = 3'h4;
  localparam logic [2:0] SPTC_MC_EXTMOD = 3'h5;

  // reset values
  localparam logic [7:0]  SPTC_CNT_RST    = 8'h01;
  localparam logic [31:0] SPTC_PERIOD_RST = 32'h0000_0064;
  localparam logic [31:0] SPTC_OFFSET_RST = 32'h0000_0000;
  localparam logic [31:0] SPTC_WIDTH_RST  = 32'h0000_000a;

  // pulse trigger mode, one-hot
  typedef enum logic [5:0] {
    SPTC_M_FREE   = 6'b000001,
    SPTC_M_GATE   = 6'b000010,
    SPTC_M_OFSREP = 6'b000100,
    SPTC_M_EDGE   = 6'b001000,
    SPTC_M_EDGOFS = 6'b010000,
    SPTC_M_EXTMOD = 6'b100000
  } sptc_mode_t;

  // pulse sequencer state, one-hot
  typedef enum logic [2:0] {
    SPTC_SQ_IDLE  = 3'b001,
    SPTC_SQ_WAIT  = 3'b010,
    SPTC_SQ_BURST = 3'b100
  } sptc_seq_t;

endpackage

// file: sptc_top_properties.sv
// checker for bus handshake, sweep arming and pulse output relations
// assumes binding to sptc_top; one clock domain, async active-low reset
`timescale 1ns/10ps
module sptc_top_chk (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  input  wire logic        sweep_start_o,
  input  wire logic        sweep_armed_o,
  input  wire logic        pulse_o,
  input  wire logic        pulse_modulate_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  a_wait_first_cycle: assert property (
    $rose(avs_read_i) || $rose(avs_write_i) |-> avs_waitrequest_o) else $error("no wait in first request cycle");
  a_wait_one_cycle: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait longer than one cycle");
  a_wait_when_idle: assert property (
    !avs_read_i && !avs_write_i |-> !avs_waitrequest_o) else $error("wait raised with no request");
  a_rdata_holds: assert property (
    !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o)) else $error("read data moved without a read");
  a_start_one_cycle: assert property (
    sweep_start_o |=> !sweep_start_o) else $error("sweep start longer than one cycle");
  a_start_needs_arm: assert property (
    sweep_start_o |-> $past(sweep_armed_o)) else $error("sweep started while not armed");
  a_arm_fall_cause: assert property (
    $fell(sweep_armed_o) |-> sweep_start_o || $past(avs_write_i && !avs_waitrequest_o))
    else $error("armed cleared without fire or write");
  a_arm_rise_cause: assert property (
    $rose(sweep_armed_o) |-> $past(avs_write_i && !avs_waitrequest_o) || $past(sweep_start_o)
      || $past(avs_write_i && !avs_waitrequest_o, 2))
    else $error("armed set without write or rearm");
  a_mod_in_pulse: assert property (
    pulse_modulate_o |-> pulse_o) else $error("modulate output outside pulse");
endmodule

bind sptc_top sptc_top_chk u_chk (.clk_sys_i, .rst_b_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .sweep_start_o, .sweep_armed_o, .pulse_o, .pulse_modulate_o);

// file: sptc_far_end.sv
// far-end model: remote controller group trigger and trigger pin source
// assumes requests come from the bench on the block's clock
`timescale 1ns/10ps
module sptc_far_end (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic fire_req_i,
  input  wire logic front_lvl_i,
  input  wire logic rear_lvl_i,
  output logic      group_trigger_o,
  output logic      front_o,
  output logic      rear_o
);
  // one-cycle message per request, like a controller strobe
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      group_trigger_o <= 1'b0;
    else
      group_trigger_o <= fire_req_i;
  end

  // pins move only on request; both levels are legal at any time
  always_ff @(posedge clk_sys_i)
  begin
    front_o <= front_lvl_i;
    rear_o  <= rear_lvl_i;
  end
endmodule

// file: sptc_top_tb_top.sv
// self-checking bench for sptc_top over its avalon-mm port
// assumes the checker is bound by its own file; far end modelled separately
`timescale 1ns/10ps
module sptc_top_tb_top;
  import sptc_pkg::*;
  logic        clk_sys_i, rst_b_i, avs_read_i, avs_write_i, fire_req, front_lvl, rear_lvl;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0]  avs_byteenable_i;
  logic        avs_waitrequest_o, group_trigger_i, front_trigger_input_i, rear_trigger_input_i;
  logic        sweep_start_o, sweep_armed_o, pulse_o, pulse_modulate_o, pulse_q;
  int          n_fail, comparisons, n_start, n_rise, n_mod, d0, d1, d2;
  // rows: pulse config, front level, rear level, expected rises in 200 cycles
  logic [31:0] cfg_tab [9] = '{32'h100, 32'h102, 32'h101, 32'h101, 32'h109, 32'h103, 32'h111, 32'h111, 32'h201};
  logic        f_tab [9]   = '{0, 0, 1, 0, 0, 1, 1, 0, 1};
  logic        r_tab [9]   = '{0, 0, 0, 0, 0, 0, 0, 1, 0};
  int          e_tab [9]   = '{20, 20, 20, 0, 20, 0, 0, 20, 0};

  sptc_top u_dut (.clk_sys_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .group_trigger_i, .front_trigger_input_i,
    .rear_trigger_input_i, .sweep_start_o, .sweep_armed_o, .pulse_o, .pulse_modulate_o);
  sptc_far_end u_far (.clk_sys_i, .rst_b_i, .fire_req_i(fire_req), .front_lvl_i(front_lvl),
    .rear_lvl_i(rear_lvl), .group_trigger_o(group_trigger_i), .front_o(front_trigger_input_i),
    .rear_o(rear_trigger_input_i));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // counted on the falling edge so tests may clear them at the rising edge
  always @(negedge clk_sys_i)
  begin
    if (sweep_start_o === 1'b1) n_start++;
    if (pulse_o === 1'b1 && pulse_q !== 1'b1) n_rise++;
    if (pulse_modulate_o === 1'b1) n_mod++;
    pulse_q = pulse_o;
  end

  task automatic final_report();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_sys_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    q = avs_readdata_o;
    if (i == 50)
    begin
      n_fail++;
      final_report();
    end
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  task automatic grp();
    fire_req <= 1'b1;
    @(posedge clk_sys_i);
    fire_req <= 1'b0;
  endtask

  // drive the front pin and count cycles until the pulse shows
  task automatic measure(input logic lvl, output int d);
    front_lvl <= lvl;
    for (d = 1; d < 100; d++)
    begin
      @(posedge clk_sys_i);
      if (pulse_o === 1'b1) break;
    end
    if (d == 100)
    begin
      n_fail++;
      final_report();
    end
    repeat (30) @(posedge clk_sys_i);
  endtask

  initial
  begin
    {rst_b_i, avs_read_i, avs_write_i, fire_req, front_lvl, rear_lvl} = '0;
    avs_address_i    = 5'h00;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'hf;
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(SPTC_CTRL_OFS, 32'h0);
    rd(SPTC_PCFG_OFS, 32'h100);
    rd(SPTC_PERIOD_OFS, SPTC_PERIOD_RST);
    rd(SPTC_WIDTH_OFS, SPTC_WIDTH_RST);
    rd(5'h1c, 32'h0);
    rd(SPTC_CMD_OFS, 32'h0);
    n_start = 0;
    grp();
    wr(SPTC_CMD_OFS, 32'h4);
    repeat (4) @(posedge clk_sys_i);
    check(n_start, 0);
    wr(SPTC_CMD_OFS, 32'h1);
    grp();
    repeat (4) @(posedge clk_sys_i);
    check(n_start, 1);
    check(sweep_armed_o, 1'b0);
    wr(SPTC_CMD_OFS, 32'h1);
    wr(SPTC_CMD_OFS, 32'h4);
    repeat (4) @(posedge clk_sys_i);
    check(n_start, 2);
    wr(SPTC_CMD_OFS, 32'h1);
    wr(SPTC_CMD_OFS, 32'h8);
    repeat (4) @(posedge clk_sys_i);
    check(n_start, 3);
    wr(SPTC_CTRL_OFS, 32'h2);
    wr(SPTC_CTRL_OFS, 32'h3);
    rd(SPTC_CTRL_OFS, 32'h2);
    wr(SPTC_CMD_OFS, 32'h1);
    grp();
    wr(SPTC_CMD_OFS, 32'h8);
    repeat (4) @(posedge clk_sys_i);
    check(n_start, 3);
    wr(SPTC_CMD_OFS, 32'h2);
    check(sweep_armed_o, 1'b0);
    wr(SPTC_CMD_OFS, 32'h10);
    check(sweep_armed_o, 1'b1);
    wr(SPTC_CMD_OFS, 32'h2);
    wr(SPTC_CTRL_OFS, 32'h1);
    wr(SPTC_CMD_OFS, 32'h1);
    repeat (6) @(posedge clk_sys_i);
    check(n_start, 4);
    wr(SPTC_CTRL_OFS, 32'h5);
    wr(SPTC_CMD_OFS, 32'h1);
    repeat (20) @(posedge clk_sys_i);
    wr(SPTC_CMD_OFS, 32'h2);
    wr(SPTC_CTRL_OFS, 32'h0);
    check(n_start >= 12, 1'b1);
    wr(SPTC_PERIOD_OFS, 32'ha);
    wr(SPTC_WIDTH_OFS, 32'h2);
    wr(SPTC_OFFSET_OFS, 32'h5);
    for (int i = 0; i < 9; i++)
    begin
      front_lvl <= f_tab[i];
      rear_lvl  <= r_tab[i];
      wr(SPTC_PCFG_OFS, cfg_tab[i]);
      repeat (30) @(posedge clk_sys_i);
      n_rise = 0;
      repeat (200) @(posedge clk_sys_i);
      check(n_rise, e_tab[i]);
    end
    bus(1'b0, SPTC_STATUS_OFS, 32'h0);
    check(q[SPTC_STAT_BAD_BIT], 1'b1);
    wr(SPTC_PCFG_OFS, 32'h106);
    rd(SPTC_PCFG_OFS, 32'h101);
    front_lvl <= 1'b0;
    wr(SPTC_PCFG_OFS, 32'h103);
    repeat (30) @(posedge clk_sys_i);
    measure(1'b1, d0);
    front_lvl <= 1'b0;
    wr(SPTC_PCFG_OFS, 32'h104);
    repeat (30) @(posedge clk_sys_i);
    measure(1'b1, d1);
    check(d1 - d0, 5);
    wr(SPTC_PCFG_OFS, 32'h10b);
    repeat (30) @(posedge clk_sys_i);
    measure(1'b0, d2);
    check(d2, d0);
    wr(SPTC_PCFG_OFS, 32'h105);
    repeat (30) @(posedge clk_sys_i);
    n_mod = 0;
    measure(1'b1, d2);
    check(d2, d1);
    check(n_mod, 2);
    final_report();
  end
endmodule
